// [core/arsc_pkg.sv]
// arsc_pkg: register map, field layout, reset values and carrier types of the converter reference select control.
// assumes an 8-bit special function register port with one-cycle write and read strobes.
package arsc_pkg;
  localparam logic [7:0] ADDR_TEMP_OFFSET_LOW = 8'h85;
  localparam logic [7:0] ADDR_TEMP_OFFSET_HIGH = 8'h86;
  localparam logic [7:0] ADDR_REFERENCE_CONTROL = 8'hD1;
  localparam logic [7:0] RESET_REFERENCE_CONTROL = 8'h18;
  localparam int BIT_PRECISION_REF_ENABLE = 0;
  localparam int BIT_TEMP_SENSOR_ENABLE = 2;
  localparam int LSB_VREF_SOURCE_SELECT = 3;
  localparam int BIT_GROUND_REF_SELECT = 5;
  localparam int LSB_OFFSET_LOW_FIELD = 6;
  localparam logic [7:0] MASK_REFERENCE_CONTROL = 8'h3D;
  localparam logic [9:0] DEFAULT_TEMP_OFFSET = 10'h200;

  typedef enum logic [1:0] {
    ARSC_VREF_EXT_PIN = 2'b00,
    ARSC_VREF_SUPPLY = 2'b01,
    ARSC_VREF_DIGITAL = 2'b10,
    ARSC_VREF_HIGH_SPEED = 2'b11
  } arsc_vref_t;

  typedef enum logic [1:0] {
    ARSC_GND_PIN = 2'b00,
    ARSC_GND_ANALOG_PIN = 2'b01,
    ARSC_GND_INTERNAL = 2'b10
  } arsc_gnd_t;

  // converter phase indicators
  typedef struct packed {
    logic tracking;
    logic converting;
    logic temp_channel;
  } arsc_phase_t;

  // analog steering outputs
  typedef struct packed {
    arsc_vref_t vref_source_select;
    arsc_gnd_t ground_route;
    logic precision_ref_enable;
    logic precision_ref_to_pin;
    logic high_speed_ref_enable;
    logic temp_sensor_enable;
  } arsc_steer_t;
endpackage

// [core/arsc_ctrl.sv]
// arsc_ctrl: reference control and temperature offset registers, plus reference and ground steering.
// assumes the register port and converter phase inputs are synchronous to CLK; the factory offset is a
// non-volatile trim value held stable by the fuse block.

module arsc_ctrl
  import arsc_pkg::*;
(
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic [7:0] ADDR,
  input wire logic WR,
  input wire logic RD,
  input wire logic [7:0] WDATA,
  input wire logic [9:0] FACTORY_OFFSET,
  input wire arsc_phase_t PHASE,
  output logic [7:0] RDATA,
  output arsc_steer_t STEER
);
  logic [7:0] ref_ctrl;
  logic [7:0] next_ref_ctrl;
  logic [7:0] rdata_q;
  logic [7:0] next_rdata;
  arsc_steer_t steer_q;
  arsc_steer_t next_steer;
  logic [9:0] temp_offset_value;
  logic [9:0] next_temp_offset_value;
  logic wr_ctrl;
  logic rd_low;
  logic rd_high;
  logic rd_ctrl;
  logic rd_mapped;

  // address compare shared by the write path, the read strobes and the checks
  function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] target);
    addr_hit = (addr == target);
  endfunction

  // true when a control byte selects the self-powered high-speed reference
  function automatic logic hs_selected(input logic [7:0] ctrl);
    hs_selected = (ctrl[LSB_VREF_SOURCE_SELECT +: 2] == ARSC_VREF_HIGH_SPEED);
  endfunction

  // true while the sampling capacitor is connected to the temperature sensor
  function automatic logic temp_sampling(input arsc_phase_t ph);
    temp_sampling = ph.tracking && ph.temp_channel;
  endfunction

  // strobes qualified by address; strobes to any other address fall away
  always_comb begin
    wr_ctrl = WR && addr_hit(ADDR, ADDR_REFERENCE_CONTROL);
    rd_low = RD && addr_hit(ADDR, ADDR_TEMP_OFFSET_LOW);
    rd_high = RD && addr_hit(ADDR, ADDR_TEMP_OFFSET_HIGH);
    rd_ctrl = RD && addr_hit(ADDR, ADDR_REFERENCE_CONTROL);
    rd_mapped = rd_low || rd_high || rd_ctrl;
  end

  // only the writable bits land; unused bits stay zero
  always_comb begin
    next_ref_ctrl = ref_ctrl;
    if (wr_ctrl) begin
      next_ref_ctrl = WDATA & MASK_REFERENCE_CONTROL;
    end
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      ref_ctrl <= RESET_REFERENCE_CONTROL;
    end else begin
      ref_ctrl <= next_ref_ctrl;
    end
  end

  // offset mirrors the trim value; no reset and no write path
  always_comb begin
    next_temp_offset_value = FACTORY_OFFSET;
  end

  // no reset: the trim value is not lost with RSTN
  always_ff @(posedge CLK) begin
    temp_offset_value <= next_temp_offset_value;
  end

  // read data registered; zero whenever no mapped read is issued
  always_comb begin
    next_rdata = 8'h00;
    if (RD) begin
      case (ADDR)
        ADDR_TEMP_OFFSET_LOW: next_rdata = {temp_offset_value[1:0], 6'h00};
        ADDR_TEMP_OFFSET_HIGH: next_rdata = temp_offset_value[9:2];
        ADDR_REFERENCE_CONTROL: next_rdata = ref_ctrl;
        default: next_rdata = 8'h00;
      endcase
    end
  end

  // ground priority: temperature sampling, then high-speed conversion, then bit 5
  always_comb begin
    logic hs_sel;
    hs_sel = 1'b0;
    next_steer.vref_source_select = arsc_vref_t'(ref_ctrl[LSB_VREF_SOURCE_SELECT +: 2]);
    hs_sel = hs_selected(ref_ctrl);
    next_steer.high_speed_ref_enable = hs_sel && (PHASE.tracking || PHASE.converting);
    next_steer.precision_ref_enable = ref_ctrl[BIT_PRECISION_REF_ENABLE];
    next_steer.precision_ref_to_pin = ref_ctrl[BIT_PRECISION_REF_ENABLE];
    next_steer.temp_sensor_enable = ref_ctrl[BIT_TEMP_SENSOR_ENABLE];
    if (temp_sampling(PHASE)) begin
      next_steer.ground_route = ARSC_GND_INTERNAL;
    end else if (PHASE.converting && hs_sel) begin
      next_steer.ground_route = ARSC_GND_INTERNAL;
    end else if (ref_ctrl[BIT_GROUND_REF_SELECT]) begin
      next_steer.ground_route = ARSC_GND_ANALOG_PIN;
    end else begin
      next_steer.ground_route = ARSC_GND_PIN;
    end
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      rdata_q <= 8'h00;
      steer_q <= '{vref_source_select: ARSC_VREF_HIGH_SPEED, ground_route: ARSC_GND_PIN, default: 1'b0};
    end else begin
      rdata_q <= next_rdata;
      steer_q <= next_steer;
    end
  end

  // outputs straight from the registers
  assign RDATA = rdata_q;
  assign STEER = steer_q;

  // write, offset and steering checks
  property p_ctrl_write;
    @(posedge CLK) disable iff (!RSTN)
      wr_ctrl |=> (ref_ctrl == ($past(WDATA) & MASK_REFERENCE_CONTROL));
  endproperty
  a_ctrl_write: assert property (p_ctrl_write) else $error("reference control write wrong");

  property p_read_low;
    @(posedge CLK) disable iff (!RSTN)
      (RD && ADDR == ADDR_TEMP_OFFSET_LOW) |=> (RDATA[5:0] == 6'h00 && RDATA[7:6] == $past(temp_offset_value[1:0]));
  endproperty
  a_read_low: assert property (p_read_low) else $error("offset low read wrong");

  property p_read_high;
    @(posedge CLK) disable iff (!RSTN)
      (RD && ADDR == ADDR_TEMP_OFFSET_HIGH) |=> (RDATA == $past(temp_offset_value[9:2]));
  endproperty
  a_read_high: assert property (p_read_high) else $error("offset high read wrong");

  property p_offset_write_ignored;
    @(posedge CLK) disable iff (!RSTN)
      (WR && ADDR == ADDR_TEMP_OFFSET_LOW && $stable(FACTORY_OFFSET)) |=> $stable(temp_offset_value);
  endproperty
  a_offset_write_ignored: assert property (p_offset_write_ignored) else $error("offset changed by write");

  property p_hs_idle;
    @(posedge CLK) disable iff (!RSTN)
      (!PHASE.tracking && !PHASE.converting) |=> !STEER.high_speed_ref_enable;
  endproperty
  a_hs_idle: assert property (p_hs_idle) else $error("high-speed reference on while idle");

  property p_hs_conv;
    @(posedge CLK) disable iff (!RSTN)
      (PHASE.converting && hs_selected(ref_ctrl)) |=> (STEER.high_speed_ref_enable
        && STEER.ground_route == ARSC_GND_INTERNAL);
  endproperty
  a_hs_conv: assert property (p_hs_conv) else $error("high-speed conversion steering wrong");

  property p_temp_gnd;
    @(posedge CLK) disable iff (!RSTN)
      (PHASE.tracking && PHASE.temp_channel) |=> (STEER.ground_route == ARSC_GND_INTERNAL);
  endproperty
  a_temp_gnd: assert property (p_temp_gnd) else $error("temperature sampling ground wrong");

  property p_analog_ground_pin;
    @(posedge CLK) disable iff (!RSTN)
      (ref_ctrl[BIT_GROUND_REF_SELECT] && !PHASE.temp_channel && !hs_selected(ref_ctrl))
        |=> (STEER.ground_route == ARSC_GND_ANALOG_PIN);
  endproperty
  a_analog_ground_pin: assert property (p_analog_ground_pin) else $error("analog ground not routed");

  property p_enables;
    @(posedge CLK) disable iff (!RSTN)
      1'b1 |=> (STEER.precision_ref_enable == $past(ref_ctrl[BIT_PRECISION_REF_ENABLE])
        && STEER.temp_sensor_enable == $past(ref_ctrl[BIT_TEMP_SENSOR_ENABLE]));
  endproperty
  a_enables: assert property (p_enables) else $error("enable steering wrong");

  // read, hold and offset checks: mapped addresses answer, everything else reads zero
  property p_read_ctrl;
    @(posedge CLK) disable iff (!RSTN)
      rd_ctrl |=> (RDATA == $past(ref_ctrl) && (RDATA & ~MASK_REFERENCE_CONTROL) == 8'h00);
  endproperty
  a_read_ctrl: assert property (p_read_ctrl) else $error("reference control read wrong");

  property p_read_quiet;
    @(posedge CLK) disable iff (!RSTN)
      !rd_mapped |=> (RDATA == 8'h00);
  endproperty
  a_read_quiet: assert property (p_read_quiet) else $error("read data not zero");

  property p_ctrl_hold;
    @(posedge CLK) disable iff (!RSTN)
      !wr_ctrl |=> $stable(ref_ctrl);
  endproperty
  a_ctrl_hold: assert property (p_ctrl_hold) else $error("reference control changed without write");

  property p_ctrl_bits_zero;
    @(posedge CLK) disable iff (!RSTN)
      (ref_ctrl & ~MASK_REFERENCE_CONTROL) == 8'h00;
  endproperty
  a_ctrl_bits_zero: assert property (p_ctrl_bits_zero) else $error("unused control bits set");

  property p_offset_high_write_ignored;
    @(posedge CLK) disable iff (!RSTN)
      (WR && addr_hit(ADDR, ADDR_TEMP_OFFSET_HIGH) && $stable(FACTORY_OFFSET)) |=> $stable(temp_offset_value);
  endproperty
  a_offset_high_write_ignored: assert property (p_offset_high_write_ignored) else $error("offset changed by write");

  property p_offset_follow;
    @(posedge CLK) disable iff (!RSTN)
      1'b1 |=> (temp_offset_value == $past(FACTORY_OFFSET));
  endproperty
  a_offset_follow: assert property (p_offset_follow) else $error("offset does not follow trim");

  // steering side
  property p_vref_select;
    @(posedge CLK) disable iff (!RSTN)
      1'b1 |=> (STEER.vref_source_select == $past(ref_ctrl[LSB_VREF_SOURCE_SELECT +: 2]));
  endproperty
  a_vref_select: assert property (p_vref_select) else $error("reference source wrong");

  property p_to_pin;
    @(posedge CLK) disable iff (!RSTN)
      1'b1 |=> (STEER.precision_ref_to_pin == $past(ref_ctrl[BIT_PRECISION_REF_ENABLE]));
  endproperty
  a_to_pin: assert property (p_to_pin) else $error("precision reference pin connection wrong");

  property p_temp_sense;
    @(posedge CLK) disable iff (!RSTN)
      1'b1 |=> (STEER.temp_sensor_enable == $past(ref_ctrl[BIT_TEMP_SENSOR_ENABLE]));
  endproperty
  a_temp_sense: assert property (p_temp_sense) else $error("temperature sensor enable wrong");

  property p_plain_gnd;
    @(posedge CLK) disable iff (!RSTN)
      (!ref_ctrl[BIT_GROUND_REF_SELECT] && !temp_sampling(PHASE) && !(PHASE.converting && hs_selected(ref_ctrl)))
        |=> (STEER.ground_route == ARSC_GND_PIN);
  endproperty
  a_plain_gnd: assert property (p_plain_gnd) else $error("plain ground not routed");

  property p_analog_ground_pin_track;
    @(posedge CLK) disable iff (!RSTN)
      (ref_ctrl[BIT_GROUND_REF_SELECT] && PHASE.tracking && !PHASE.temp_channel && !PHASE.converting)
        |=> (STEER.ground_route == ARSC_GND_ANALOG_PIN);
  endproperty
  a_analog_ground_pin_track: assert property (p_analog_ground_pin_track) else $error("analog ground lost while tracking");

  property p_analog_ground_pin_convert;
    @(posedge CLK) disable iff (!RSTN)
      (ref_ctrl[BIT_GROUND_REF_SELECT] && PHASE.converting && !hs_selected(ref_ctrl) && !temp_sampling(PHASE))
        |=> (STEER.ground_route == ARSC_GND_ANALOG_PIN);
  endproperty
  a_analog_ground_pin_convert: assert property (p_analog_ground_pin_convert) else $error("analog ground lost while converting");

  property p_hs_track;
    @(posedge CLK) disable iff (!RSTN)
      (PHASE.tracking && hs_selected(ref_ctrl)) |=> STEER.high_speed_ref_enable;
  endproperty
  a_hs_track: assert property (p_hs_track) else $error("high-speed reference off while tracking");

  property p_hs_unselected;
    @(posedge CLK) disable iff (!RSTN)
      !hs_selected(ref_ctrl) |=> !STEER.high_speed_ref_enable;
  endproperty
  a_hs_unselected: assert property (p_hs_unselected) else $error("high-speed reference on while unselected");

  property p_gnd_internal;
    @(posedge CLK) disable iff (!RSTN)
      (STEER.ground_route == ARSC_GND_INTERNAL)
        |-> ($past(temp_sampling(PHASE)) || $past(PHASE.converting && hs_selected(ref_ctrl)));
  endproperty
  a_gnd_internal: assert property (p_gnd_internal) else $error("internal ground without cause");

  c_hs_conversion: cover property (@(posedge CLK) disable iff (!RSTN) STEER.high_speed_ref_enable);
  c_analog_ground_pin: cover property (@(posedge CLK) disable iff (!RSTN) STEER.ground_route == ARSC_GND_ANALOG_PIN);
  c_temp: cover property (@(posedge CLK) disable iff (!RSTN) STEER.temp_sensor_enable && PHASE.temp_channel);
  c_precision: cover property (@(posedge CLK) disable iff (!RSTN) STEER.precision_ref_enable);
  c_ctrl_read: cover property (@(posedge CLK) disable iff (!RSTN) rd_ctrl);
endmodule

// [dv/arsc_conv_model.sv]
// arsc_conv_model: converter sequencer that drives the phase indicators.
// assumes a pulse on start; tracking lasts two cycles, converting five.
module arsc_conv_model
  import arsc_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic start,
  input wire logic temp,
  output arsc_phase_t phase
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] cnt;
  logic [2:0] next_cnt;
  always_comb begin
    next_cnt = cnt;
    if (start) next_cnt = 3'h1;
    else if (cnt != 3'h0) next_cnt = cnt + 3'h1;
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) cnt <= 3'h0;
    else cnt <= next_cnt;
  end
  assign phase = '{cnt inside {3'h1, 3'h2}, cnt > 3'h2, temp && cnt != 3'h0};
endmodule

// [dv/tb_adc_reference_select_control.sv]
// tb_adc_reference_select_control: table of register writes, then offsets, refusals and reset.
// assumes the sequencer model drives the phase inputs.
module tb_adc_reference_select_control
  import arsc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, rstn = 0, wr = 0, rd = 0, go = 0, tch = 0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
  logic [9:0] fo = 10'h2B5;
  arsc_phase_t ph;
  arsc_steer_t st;
  int n_errors = 0, checked = 0;
  localparam logic [7:0] ROWS [6][2] = '{'{8'hFF, 8'h3D}, '{8'h00, 8'h00}, '{8'h02, 8'h00},
    '{8'hC1, 8'h01}, '{8'h2C, 8'h2C}, '{8'h34, 8'h34}};
  always #25 clk = ~clk;
  arsc_ctrl arsc_ctrl_inst(.CLK(clk), .RSTN(rstn), .ADDR(addr), .WR(wr), .RD(rd), .WDATA(wdata),
    .FACTORY_OFFSET(fo), .PHASE(ph), .RDATA(rdata), .STEER(st));
  arsc_conv_model arsc_conv_model_inst(.clk(clk), .rstn(rstn), .start(go), .temp(tch), .phase(ph));
  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmps(input arsc_steer_t got, input arsc_steer_t exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #1 addr = a;
    wdata = d;
    wr = 1;
    @(posedge clk);
    #1 wr = 0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    #1 addr = a;
    rd = 1;
    @(posedge clk);
    #1 rd = 0;
    cmp8(rdata, exp);
  endtask
  // steering worked out from the control byte and the phase seen one cycle earlier
  function automatic arsc_steer_t exp_st(input logic [7:0] r, input arsc_phase_t p);
    exp_st = '{arsc_vref_t'(r[4:3]), arsc_gnd_t'({1'b0, r[5]}), r[0], r[0], 1'b0, r[2]};
    if (r[4:3] == 2'b11 && (p.tracking || p.converting)) exp_st.high_speed_ref_enable = 1'b1;
    if ((p.tracking && p.temp_channel) || (r[4:3] == 2'b11 && p.converting))
      exp_st.ground_route = ARSC_GND_INTERNAL;
  endfunction
  task automatic conv(input logic [7:0] r, input logic t);
    arsc_phase_t p;
    tch = t;
    go = 1;
    @(posedge clk);
    #1 go = 0;
    repeat (8) begin
      p = ph;
      @(posedge clk);
      #1 cmps(st, exp_st(r, p));
    end
  endtask
  task automatic complete_run;
    $display("errors=%0d checked=%0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    #100000;
    n_errors++;
    complete_run();
  end
  initial begin
    repeat (4) @(posedge clk);
    cmps(st, exp_st(RESET_REFERENCE_CONTROL, '0));
    #1 rstn = 1;
    rd_chk(ADDR_REFERENCE_CONTROL, RESET_REFERENCE_CONTROL);
    for (int i = 0; i < 6; i++) begin
      wr_reg(ADDR_REFERENCE_CONTROL, ROWS[i][0]);
      rd_chk(ADDR_REFERENCE_CONTROL, ROWS[i][1]);
      cmps(st, exp_st(ROWS[i][1], '0));
      conv(ROWS[i][1], 1'(i));
    end
    rd_chk(ADDR_TEMP_OFFSET_LOW, {fo[1:0], 6'h00});
    rd_chk(ADDR_TEMP_OFFSET_HIGH, fo[9:2]);
    wr_reg(ADDR_TEMP_OFFSET_LOW, 8'h3F);
    wr_reg(ADDR_TEMP_OFFSET_HIGH, ~fo[9:2]);
    wr_reg(8'h87, 8'hFF);
    rd_chk(ADDR_TEMP_OFFSET_LOW, {fo[1:0], 6'h00});
    rd_chk(ADDR_TEMP_OFFSET_HIGH, fo[9:2]);
    rd_chk(8'h87, 8'h00);
    rd_chk(ADDR_REFERENCE_CONTROL, 8'h34);
    @(posedge clk);
    #1 cmp8(rdata, 8'h00);
    rstn = 0;
    repeat (2) @(posedge clk);
    #1 rstn = 1;
    rd_chk(ADDR_TEMP_OFFSET_HIGH, fo[9:2]);
    rd_chk(ADDR_REFERENCE_CONTROL, RESET_REFERENCE_CONTROL);
    complete_run();
  end
endmodule
